/* File: logic/kwt_watchdog.sv */
// Notes on behaviour
// - Timer counter advances on prescaler ticks
// - Period and prescale are software programmable
// - Missed restart before time-out requests reset
// - Time-out interrupt is optional, software selected
// - Debug mode suppresses the reset request
// - Debug-mode interrupt needs interrupt enable set
// - Writing clear register drops pending interrupt
// - Halted processor plus pause bit stalls counting
// - Control writes need the correct key
// - Reset request goes to chip reset generator
// - Counters run on always-on safe clock
// - Registers on bus clock, counters on safe
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module kwt_watchdog #(
  parameter int unsigned CNT_W = 32
) (
  input wire logic clk, // Peripheral bus clock, 200 MHz
  input wire logic reset, // Sync reset, active high
  input wire logic clk_safe, // Always-on safe clock
  input wire logic cpu_debug_halt, // Processor halted in debug
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic wdt_irq, // Time-out interrupt, safe domain
  output logic wdt_reset_req // To chip_reset_generator, safe domain
);
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("kwt_watchdog CNT_W must be 2 to 32");
  end

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  // Bus clock domain
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [kwt_pkg::CTRL_W-1:0] ctrl_reg;
  logic [CNT_W-1:0] period_reg;
  logic [CNT_W-1:0] prescale_reg;
  logic int_en_reg;
  logic [1:0] stat_s1_reg;
  logic [1:0] stat_s2_reg;

  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_we_i & ack_reg & (&wb_sel_i);
  wire hit_ctrl = hit(wb_adr_i, kwt_pkg::OFS_CTRL);
  wire hit_period = hit(wb_adr_i, kwt_pkg::OFS_PERIOD);
  wire hit_prescale = hit(wb_adr_i, kwt_pkg::OFS_PRESCALE);
  wire hit_restart = hit(wb_adr_i, kwt_pkg::OFS_RESTART);
  wire hit_int_en = hit(wb_adr_i, kwt_pkg::OFS_INT_EN);
  wire hit_int_clr = hit(wb_adr_i, kwt_pkg::OFS_INT_CLR);
  wire hit_status = hit(wb_adr_i, kwt_pkg::OFS_STATUS);
  wire key_ok = wb_dat_i[kwt_pkg::CTRL_KEY_LSB +: 16] == kwt_pkg::CTRL_KEY;
  wire wr_ctrl = bus_wr & hit_ctrl & key_ok;
  wire restart_pulse = bus_wr & hit_restart;
  wire clear_pulse = bus_wr & hit_int_clr;

  assign ack_next = bus_req & ~ack_reg;
  wire [31:0] rd_ctrl = 32'(ctrl_reg);
  wire [31:0] rd_status = 32'(stat_s2_reg);
  assign rdata_next = hit_ctrl ? rd_ctrl :
    hit_period ? 32'(period_reg) :
    hit_prescale ? 32'(prescale_reg) :
    hit_int_en ? 32'(int_en_reg) :
    hit_status ? rd_status : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= ack_next ? rdata_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= kwt_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= wb_dat_i[kwt_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      period_reg <= kwt_pkg::PERIOD_RESET[CNT_W-1:0];
      prescale_reg <= kwt_pkg::PRESCALE_RESET[CNT_W-1:0];
      int_en_reg <= kwt_pkg::INT_EN_RESET;
    end else begin
      if (bus_wr & hit_period) begin
        period_reg <= wb_dat_i[CNT_W-1:0];
      end
      if (bus_wr & hit_prescale) begin
        prescale_reg <= wb_dat_i[CNT_W-1:0];
      end
      if (bus_wr & hit_int_en) begin
        int_en_reg <= wb_dat_i[0];
      end
    end
  end

  // Status back from the safe domain, level crossing
  always_ff @(posedge clk) begin
    if (reset) begin
      stat_s1_reg <= 2'h0;
      stat_s2_reg <= 2'h0;
    end else begin
      stat_s1_reg[kwt_pkg::STAT_IRQ_BIT] <= wdt_irq;
      stat_s1_reg[kwt_pkg::STAT_RESET_BIT] <= wdt_reset_req;
      stat_s2_reg <= stat_s1_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // Safe clock domain
  // reset carried into safe domain
  logic srst_s1_reg;
  logic srst_reg;
  always_ff @(posedge clk_safe) begin
    srst_s1_reg <= reset;
    srst_reg <= srst_s1_reg;
  end

  logic restart_evt;
  logic clear_evt;
  kwt_evt_sync #(.STAGES(kwt_pkg::SYNC_STAGES)) u_restart_sync (
    .clk_src(clk),
    .rst_src(reset),
    .pulse_src(restart_pulse),
    .clk_dst(clk_safe),
    .rst_dst(srst_reg),
    .pulse_dst(restart_evt)
  );
  kwt_evt_sync #(.STAGES(kwt_pkg::SYNC_STAGES)) u_clear_sync (
    .clk_src(clk),
    .rst_src(reset),
    .pulse_src(clear_pulse),
    .clk_dst(clk_safe),
    .rst_dst(srst_reg),
    .pulse_dst(clear_evt)
  );

  localparam int unsigned LVL_W = kwt_pkg::CTRL_W + 2;
  logic [LVL_W-1:0] lvl_s1_reg;
  logic [LVL_W-1:0] lvl_s2_reg;
  always_ff @(posedge clk_safe) begin
    if (srst_reg) begin
      lvl_s1_reg <= '0;
      lvl_s2_reg <= '0;
    end else begin
      lvl_s1_reg <= {cpu_debug_halt, int_en_reg, ctrl_reg};
      lvl_s2_reg <= lvl_s1_reg;
    end
  end
  wire en_s = lvl_s2_reg[kwt_pkg::CTRL_ENABLE_BIT];
  wire debug_s = lvl_s2_reg[kwt_pkg::CTRL_DEBUG_BIT];
  wire pause_s = lvl_s2_reg[kwt_pkg::CTRL_PAUSE_BIT];
  wire int_en_s = lvl_s2_reg[kwt_pkg::CTRL_W];
  wire halt_s = lvl_s2_reg[kwt_pkg::CTRL_W + 1];

  // Safe copies of the limits: follow while stopped, load on restart,
  // so a half-written word never reaches a running counter
  logic [CNT_W-1:0] per_copy_reg;
  logic [CNT_W-1:0] pre_copy_reg;
  always_ff @(posedge clk_safe) begin
    if (srst_reg) begin
      per_copy_reg <= kwt_pkg::PERIOD_RESET[CNT_W-1:0];
      pre_copy_reg <= kwt_pkg::PRESCALE_RESET[CNT_W-1:0];
    end else if (~en_s | restart_evt) begin
      per_copy_reg <= period_reg;
      pre_copy_reg <= prescale_reg;
    end
  end

  logic [CNT_W-1:0] pre_cnt_reg;
  logic [CNT_W-1:0] tmr_cnt_reg;
  logic [CNT_W-1:0] pre_cnt_next;
  logic [CNT_W-1:0] tmr_cnt_next;
  logic irq_next;
  logic rst_req_next;
  logic irq_reg;
  logic rst_req_reg;

  wire run = en_s & ~(pause_s & halt_s);
  wire tick = run & (pre_cnt_reg == pre_copy_reg);
  wire tmr_end = tmr_cnt_reg == per_copy_reg;
  wire timeout = tick & tmr_end & ~restart_evt;

  assign pre_cnt_next = restart_evt ? '0 :
    ~run ? pre_cnt_reg :
    tick ? '0 : pre_cnt_reg + CNT_W'(1);
  assign tmr_cnt_next = restart_evt ? '0 :
    ~tick ? tmr_cnt_reg :
    tmr_end ? '0 : tmr_cnt_reg + CNT_W'(1);
  assign irq_next = (timeout & int_en_s) | (irq_reg & ~clear_evt);
  // time-out resets, except in debug mode
  assign rst_req_next = rst_req_reg | (timeout & ~debug_s);

  always_ff @(posedge clk_safe) begin
    if (srst_reg) begin
      pre_cnt_reg <= '0;
      tmr_cnt_reg <= '0;
      irq_reg <= 1'b0;
      rst_req_reg <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
      tmr_cnt_reg <= tmr_cnt_next;
      irq_reg <= irq_next;
      rst_req_reg <= rst_req_next;
    end
  end

  assign wdt_irq = irq_reg;
  assign wdt_reset_req = rst_req_reg;

  key_guard_a: assert property (
    @(posedge clk) disable iff (reset)
    bus_wr & hit_ctrl & ~key_ok |=> ctrl_reg == $past(ctrl_reg))
    else $error("Unkeyed control write changed the control register");

  period_write_a: assert property (
    @(posedge clk) disable iff (reset)
    bus_wr & hit_period |=> period_reg == $past(wb_dat_i[CNT_W-1:0]))
    else $error("Period write not stored");

  tick_advance_a: assert property (
    @(posedge clk_safe) disable iff (srst_reg)
    tick & ~tmr_end & ~restart_evt
      |=> tmr_cnt_reg == $past(tmr_cnt_reg) + CNT_W'(1))
    else $error("Timer did not advance on prescaler tick");

  reset_on_timeout_a: assert property (
    @(posedge clk_safe) disable iff (srst_reg)
    timeout & ~debug_s |=> wdt_reset_req)
    else $error("Time-out without reset request");

  debug_no_reset_a: assert property (
    @(posedge clk_safe) disable iff (srst_reg)
    ~wdt_reset_req & (~timeout | debug_s) |=> ~wdt_reset_req)
    else $error("Reset request raised without cause or in debug mode");

  irq_needs_enable_a: assert property (
    @(posedge clk_safe) disable iff (srst_reg)
    ~wdt_irq & ~(timeout & int_en_s) |=> ~wdt_irq)
    else $error("Interrupt raised while not enabled");

  irq_on_timeout_a: assert property (
    @(posedge clk_safe) disable iff (srst_reg)
    timeout & int_en_s |=> wdt_irq)
    else $error("Enabled time-out did not raise the interrupt");

  irq_clear_a: assert property (
    @(posedge clk_safe) disable iff (srst_reg)
    wdt_irq & clear_evt & ~timeout |=> ~wdt_irq)
    else $error("Interrupt not cleared");

  pause_stall_a: assert property (
    @(posedge clk_safe) disable iff (srst_reg)
    pause_s & halt_s & ~restart_evt
      |=> $stable(pre_cnt_reg) && $stable(tmr_cnt_reg))
    else $error("Counters moved while paused");

  restart_load_a: assert property (
    @(posedge clk_safe) disable iff (srst_reg)
    restart_evt |=> pre_cnt_reg == '0 && tmr_cnt_reg == '0)
    else $error("Restart did not reload the counters");

  req_hold_a: assert property (
    @(posedge clk_safe) disable iff (srst_reg)
    wdt_reset_req |=> wdt_reset_req [*3])
    else $error("Reset request dropped before reset");
endmodule // kwt_watchdog
`default_nettype wire

/* File: logic/kwt_pkg.sv */
`default_nettype none
package kwt_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_PRESCALE = 8'h08;
  localparam logic [7:0] OFS_RESTART = 8'h0C;
  localparam logic [7:0] OFS_INT_EN = 8'h10;
  localparam logic [7:0] OFS_INT_CLR = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Control register layout
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_DEBUG_BIT = 1;
  localparam int unsigned CTRL_PAUSE_BIT = 2;
  localparam int unsigned CTRL_KEY_LSB = 16;
  localparam logic [15:0] CTRL_KEY = 16'hA5C3;

  // Status register layout
  localparam int unsigned STAT_IRQ_BIT = 0;
  localparam int unsigned STAT_RESET_BIT = 1;

  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  localparam logic [31:0] PERIOD_RESET = 32'h0000_FFFF;
  localparam logic [31:0] PRESCALE_RESET = 32'h0000_0000;
  localparam logic INT_EN_RESET = 1'b0;

  // Synchroniser depth, in destination clock cycles
  localparam int unsigned SYNC_STAGES = 2;
endpackage : kwt_pkg
`default_nettype wire

/* File: logic/kwt_evt_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module kwt_evt_sync #(
  parameter int unsigned STAGES = kwt_pkg::SYNC_STAGES
) (
  input wire logic clk_src, // Source clock
  input wire logic rst_src, // Source reset, sync, high
  input wire logic pulse_src, // One-cycle event in source domain
  input wire logic clk_dst, // Destination clock
  input wire logic rst_dst, // Destination reset, sync, high
  output logic pulse_dst // One-cycle event in destination domain
);
  logic toggle_reg;
  logic [STAGES-1:0] sync_reg;
  logic last_reg;

  if (STAGES < 2) begin : g_bad_stages
    $error("kwt_evt_sync needs at least two stages");
  end

  // Toggle survives any ratio of clocks; events must be spaced wider
  // than the destination sync delay or two of them cancel
  always_ff @(posedge clk_src) begin
    if (rst_src) begin
      toggle_reg <= 1'b0;
    end else if (pulse_src) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  always_ff @(posedge clk_dst) begin
    if (rst_dst) begin
      sync_reg <= '0;
      last_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[STAGES-2:0], toggle_reg};
      last_reg <= sync_reg[STAGES-1];
    end
  end

  assign pulse_dst = sync_reg[STAGES-1] ^ last_reg;
endmodule // kwt_evt_sync
`default_nettype wire

/* File: verif/kwt_watchdog_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module kwt_watchdog_tb;
  logic clk = 1'b0;
  logic clk_safe = 1'b0;
  logic reset = 1'b1;
  logic cpu_debug_halt = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic wdt_irq;
  logic wdt_reset_req;
  int mismatches = 0;
  int n_tests = 0;
  int i;
  logic [31:0] rd;
  logic [31:0] key_w;
  logic [7:0] adr_t [8];
  logic [31:0] exp_t [8];

  always #2.5 clk = ~clk;
  // Safe clock slower and phase shifted, unrelated to the bus clock
  initial begin
    #1.3;
    forever #3.5 clk_safe = ~clk_safe;
  end

  kwt_watchdog #(.CNT_W(32)) DUT (
    .clk(clk), .reset(reset), .clk_safe(clk_safe),
    .cpu_debug_halt(cpu_debug_halt), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req)
  );

  task end_sim;
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task wb_cycle(input logic we, input logic [7:0] adr,
                input logic [31:0] dat, input logic [3:0] sel,
                output logic [31:0] q);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("[ERR] %0t no bus acknowledge", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_cycle(1'b1, adr, dat, 4'hF, rd);
  endtask

  task rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb_cycle(1'b0, adr, 32'h0000_0000, 4'hF, rd);
    check(rd, exp);
  endtask

  // Safe domain needs several bus edges to see the reset
  task do_reset;
    reset <= 1'b1;
    wait_clk(10);
    reset <= 1'b0;
    wait_clk(4);
  endtask

  task wait_irq;
    for (i = 0; i < 80 && wdt_irq !== 1'b1; i++) @(posedge clk);
  endtask

  initial begin
    #20000;
    mismatches++;
    $display("[ERR] %0t run did not finish", $time);
    end_sim;
  end

  initial begin
    key_w = {kwt_pkg::CTRL_KEY, 16'h0000};
    adr_t = '{kwt_pkg::OFS_CTRL, kwt_pkg::OFS_PERIOD, kwt_pkg::OFS_PRESCALE,
      kwt_pkg::OFS_RESTART, kwt_pkg::OFS_INT_EN, kwt_pkg::OFS_INT_CLR,
      kwt_pkg::OFS_STATUS, 8'h1C};
    exp_t = '{32'h0000_0000, kwt_pkg::PERIOD_RESET, kwt_pkg::PRESCALE_RESET,
      32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000};
    do_reset;
    for (int k = 0; k < 8; k++) rdchk(adr_t[k], exp_t[k]);
    wr(8'h1C, 32'hFFFF_FFFF);
    rdchk(8'h1C, 32'h0000_0000);
    wb_cycle(1'b1, kwt_pkg::OFS_PERIOD, 32'h0000_0055, 4'h7, rd);
    rdchk(kwt_pkg::OFS_PERIOD, kwt_pkg::PERIOD_RESET);
    wr(kwt_pkg::OFS_CTRL, 32'h0000_0007);
    rdchk(kwt_pkg::OFS_CTRL, 32'h0000_0000);
    wr(kwt_pkg::OFS_PERIOD, 32'h0000_000F);
    wr(kwt_pkg::OFS_PRESCALE, 32'h0000_0001);
    rdchk(kwt_pkg::OFS_PERIOD, 32'h0000_000F);
    rdchk(kwt_pkg::OFS_PRESCALE, 32'h0000_0001);
    wr(kwt_pkg::OFS_INT_EN, 32'h0000_0001);
    wr(kwt_pkg::OFS_CTRL, key_w | 32'h0000_0001);
    rdchk(kwt_pkg::OFS_CTRL, 32'h0000_0001);
    // Time-out is 32 safe cycles; restart well inside it
    // period loaded, periodic restarts
    wr(kwt_pkg::OFS_RESTART, 32'h0000_0000);
    repeat (6) begin
      wait_clk(20);
      wr(kwt_pkg::OFS_RESTART, 32'h0000_0000);
    end
    check(32'(wdt_reset_req), 32'h0);
    // Past 16 safe cycles: trips if the prescaler is skipped
    wait_clk(35);
    check(32'(wdt_reset_req), 32'h0);
    for (i = 0; i < 100 && wdt_reset_req !== 1'b1; i++) @(posedge clk);
    check(32'(wdt_reset_req), 32'h1);
    check(32'(wdt_irq), 32'h1);
    wait_clk(4);
    rdchk(kwt_pkg::OFS_STATUS, 32'h0000_0003);
    wr(kwt_pkg::OFS_RESTART, 32'h0000_0000);
    wait_clk(6);
    wr(kwt_pkg::OFS_INT_CLR, 32'h0000_0000);
    wait_clk(8);
    check(32'(wdt_irq), 32'h0);
    check(32'(wdt_reset_req), 32'h1);
    do_reset;
    check(32'(wdt_reset_req), 32'h0);
    wr(kwt_pkg::OFS_PERIOD, 32'h0000_0003);
    wr(kwt_pkg::OFS_CTRL, key_w | 32'h0000_0003);
    wr(kwt_pkg::OFS_RESTART, 32'h0000_0000);
    wait_clk(60);
    check(32'(wdt_reset_req), 32'h0);
    check(32'(wdt_irq), 32'h0);
    wr(kwt_pkg::OFS_INT_EN, 32'h0000_0001);
    wait_irq;
    check(32'(wdt_irq), 32'h1);
    check(32'(wdt_reset_req), 32'h0);
    cpu_debug_halt <= 1'b1;
    wr(kwt_pkg::OFS_CTRL, key_w | 32'h0000_0007);
    wait_clk(10);
    wr(kwt_pkg::OFS_INT_CLR, 32'h0000_0000);
    wait_clk(60);
    check(32'(wdt_irq), 32'h0);
    rdchk(kwt_pkg::OFS_CTRL, 32'h0000_0007);
    cpu_debug_halt <= 1'b0;
    wait_irq;
    check(32'(wdt_irq), 32'h1);
    end_sim;
  end
endmodule // kwt_watchdog_tb
`default_nettype wire
